// >>> common/usc_map.vh
// register map, field positions and reset values of the serial control block
`ifndef USC_MAP_VH
`define USC_MAP_VH

// register byte offsets
`define USC_OFF_CTRL      4'h0
`define USC_OFF_STAT      4'h4
`define USC_OFF_DATA      4'h8
`define USC_OFF_PORT      4'hc

// control register fields
`define USC_CTRL_SIE      7
`define USC_CTRL_OIE      6
`define USC_CTRL_WM_HI    5
`define USC_CTRL_WM_LO    4
`define USC_CTRL_CS1      3
`define USC_CTRL_CS0      2
`define USC_CTRL_CLK      1
`define USC_CTRL_TC       0
`define USC_CTRL_RST      8'h00
`define USC_CTRL_RMASK    8'hfc

// status register fields
`define USC_STAT_SIF      7
`define USC_STAT_OIF      6

// port register fields
`define USC_PORT_DO       0
`define USC_PORT_SDA      1
`define USC_PORT_SCL      2
`define USC_PORT_DDR_DO   4
`define USC_PORT_DDR_SDA  5
`define USC_PORT_DDR_SCL  6
`define USC_PORT_RST      8'h00

// wire modes
`define USC_WM_OFF        2'h0
`define USC_WM_THREE      2'h1
`define USC_WM_TWO        2'h2
`define USC_WM_TWO_HOLD   2'h3

// axi answers
`define USC_RESP_OKAY     2'h0
`define USC_RESP_SLVERR   2'h2

`endif

// >>> rtl/usc_shift.v
// 8-bit shift register and 4-bit counter of the serial unit
`timescale 1ns/1ps
`default_nettype none

module usc_shift (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       shift_en,
	input  wire       shift_in,
	input  wire       load,
	input  wire [7:0] load_data,
	input  wire       cnt_inc,
	input  wire       cnt_load,
	input  wire [3:0] cnt_data,
	output reg  [7:0] data,
	output reg  [3:0] cnt,
	output wire       wrap
);

// counter wraps from 15 to 0 on an increment not overridden by a load
assign wrap = cnt_inc & ~cnt_load & (cnt == 4'hf);

// a software write wins over a shift in the same cycle
always @(posedge aclk) begin
	if (!aresetn) begin
		data <= 8'h00;
	end else if (load) begin
		data <= load_data;
	end else if (shift_en) begin
		data <= {data[6:0], shift_in};
	end
end

// counter, software load wins over an increment
always @(posedge aclk) begin
	if (!aresetn) begin
		cnt <= 4'h0;
	end else if (cnt_load) begin
		cnt <= cnt_data;
	end else if (cnt_inc) begin
		cnt <= cnt + 4'h1;
	end
end

endmodule

`default_nettype wire

// >>> rtl/usc_sync.v
// two flip-flop synchroniser for the serial pin inputs
`timescale 1ns/1ps
`default_nettype none

module usc_sync #(
	parameter WIDTH = 2
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

// first stage feeds only the second stage
always @(posedge aclk) begin
	if (!aresetn) begin
		meta     <= {WIDTH{1'b0}};
		sync_out <= {WIDTH{1'b0}};
	end else begin
		meta     <= async_in;
		sync_out <= meta;
	end
end

endmodule

`default_nettype wire

// >>> rtl/usc_top.v
// serial unit control: register slave, clocking, pin drive and flags
`timescale 1ns/1ps
`default_nettype none
`include "usc_map.vh"

module usc_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        global_irq_enable,
	input  wire        timer0_overflow,
	input  wire        serial_data_in_pin_i,
	output reg         serial_data_in_pin_o,
	output reg         serial_data_in_pin_oe,
	output reg         serial_data_in_pullup,
	input  wire        serial_clock_pin_i,
	output reg         serial_clock_pin_o,
	output reg         serial_clock_pin_oe,
	output reg         serial_clock_pullup,
	output reg         data_out_pin_o,
	output reg         data_out_pin_oe,
	output reg         data_out_pullup,
	output reg         start_irq,
	output reg         overflow_irq
);

////////////////////////////////////////////////////////////////////////////////
// state

reg  [7:0] serial_unit_control;
reg        clock_strobe_bit;
reg        start_flag;
reg        counter_overflow_flag;
reg  [7:0] port_reg;
reg  [3:0] aw_addr;
reg        aw_held;
reg [31:0] w_data;
reg  [3:0] w_strb;
reg        w_held;
reg        sda_prev;
reg        scl_prev;
reg        out_latch;
wire [1:0] pins_sync;
wire       sda_s;
wire       scl_s;
wire [7:0] shift_data_register;
wire [3:0] cnt;
wire       wrap;

////////////////////////////////////////////////////////////////////////////////
// decoded fields

wire [1:0] wire_mode_select = serial_unit_control[5:4];
wire [1:0] clock_source_select = serial_unit_control[3:2];
wire       ext_clk = clock_source_select[1];
wire       two_wire = wire_mode_select[1];
wire       three_wire = (wire_mode_select == `USC_WM_THREE);
wire       port_do = port_reg[`USC_PORT_DO];
wire       port_sda = port_reg[`USC_PORT_SDA];
wire       port_scl = port_reg[`USC_PORT_SCL];
wire       ddr_do = port_reg[`USC_PORT_DDR_DO];
wire       ddr_sda = port_reg[`USC_PORT_DDR_SDA];
wire       clock_pin_direction_bit = port_reg[`USC_PORT_DDR_SCL];

////////////////////////////////////////////////////////////////////////////////
// bus write path

wire do_write = aw_held & w_held & ~s_axi_bvalid;
wire wr_lane0 = do_write & w_strb[0];
wire wr_ctrl = wr_lane0 & (aw_addr == `USC_OFF_CTRL);
wire wr_stat = wr_lane0 & (aw_addr == `USC_OFF_STAT);
wire wr_data = wr_lane0 & (aw_addr == `USC_OFF_DATA);
wire wr_port = wr_lane0 & (aw_addr == `USC_OFF_PORT);
wire wr_mapped = (aw_addr == `USC_OFF_CTRL) | (aw_addr == `USC_OFF_STAT) |
	(aw_addr == `USC_OFF_DATA) | (aw_addr == `USC_OFF_PORT);
wire [7:0] wbyte = w_data[7:0];

// address and data are taken in either order, answered once both are held
always @(posedge aclk) begin
	if (!aresetn) begin
		aw_held       <= 1'b0;
		w_held        <= 1'b0;
		aw_addr       <= 4'h0;
		w_data        <= 32'h0000_0000;
		w_strb        <= 4'h0;
		s_axi_awready <= 1'b0;
		s_axi_wready  <= 1'b0;
		s_axi_bvalid  <= 1'b0;
		s_axi_bresp   <= `USC_RESP_OKAY;
	end else begin
		s_axi_awready <= ~aw_held & ~s_axi_bvalid &
			~(s_axi_awvalid & s_axi_awready);
		s_axi_wready  <= ~w_held & ~s_axi_bvalid &
			~(s_axi_wvalid & s_axi_wready);
		if (s_axi_awvalid & s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= {s_axi_awaddr[3:2], 2'b00};
		end
		if (s_axi_wvalid & s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (do_write) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// bus read path

reg [7:0] rd_byte;
reg       rd_ok;

// read mux, strobe bits and unused status bits read as zero
always @* begin
	rd_ok   = 1'b1;
	rd_byte = 8'h00;
	case ({s_axi_araddr[3:2], 2'b00})
	`USC_OFF_CTRL: rd_byte = serial_unit_control & `USC_CTRL_RMASK;
	`USC_OFF_STAT: rd_byte = {start_flag, counter_overflow_flag, 2'b00, cnt};
	`USC_OFF_DATA: rd_byte = shift_data_register;
	`USC_OFF_PORT: rd_byte = port_reg;
	default: rd_ok = 1'b0;
	endcase
end

// one read at a time, answered the cycle after the address is taken
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid  <= 1'b0;
		s_axi_rdata   <= 32'h0000_0000;
		s_axi_rresp   <= `USC_RESP_OKAY;
	end else begin
		s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
		if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= rd_ok ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// control and port registers

// strobe bits are never stored into the readable control image
wire clk_strobe = wr_ctrl & wbyte[`USC_CTRL_CLK];
wire tc_strobe = wr_ctrl & wbyte[`USC_CTRL_TC];

always @(posedge aclk) begin
	if (!aresetn) begin
		serial_unit_control <= `USC_CTRL_RST;
		clock_strobe_bit    <= 1'b0;
		port_reg            <= `USC_PORT_RST;
	end else begin
		if (wr_ctrl) begin
			serial_unit_control <= wbyte & `USC_CTRL_RMASK;
			clock_strobe_bit    <= wbyte[`USC_CTRL_CLK];
		end
		if (wr_port) begin
			port_reg <= wbyte;
		end
		if (tc_strobe) begin
			// toggle ignores direction; pin shows it only as output
			port_reg[`USC_PORT_SCL] <= ~port_scl;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// pin inputs, always live whatever the wire mode

usc_sync #(
	.WIDTH    (2)
) u_sync (
	.aclk     (aclk),
	.aresetn  (aresetn),
	.async_in ({serial_clock_pin_i, serial_data_in_pin_i}),
	.sync_out (pins_sync)
);

assign sda_s = pins_sync[0];
assign scl_s = pins_sync[1];

// previous synchronised levels for edge detection
always @(posedge aclk) begin
	if (!aresetn) begin
		sda_prev <= 1'b1;
		scl_prev <= 1'b0;
	end else begin
		sda_prev <= sda_s;
		scl_prev <= scl_s;
	end
end

wire scl_rise = scl_s & ~scl_prev;
wire scl_fall = ~scl_s & scl_prev;

////////////////////////////////////////////////////////////////////////////////
// clock source selection

wire new_cs1 = wbyte[`USC_CTRL_CS1];
wire sw_strobe = clk_strobe & ~new_cs1 & ~wbyte[`USC_CTRL_CS0];
wire sel_sw = (clock_source_select == 2'b00);
wire sel_timer = (clock_source_select == 2'b01);
wire ext_edge = clock_source_select[0] ? scl_fall : scl_rise;

// shift enable: strobe, timer overflow or the selected external edge
wire shift_en = (sw_strobe & sel_sw) |
	(sel_timer & timer0_overflow) |
	(ext_clk & ext_edge);

// counter: both external edges, or toggle strobe when strobe bit is set
wire cnt_inc = (sw_strobe & sel_sw) |
	(sel_timer & timer0_overflow) |
	(ext_clk & ~clock_strobe_bit & (scl_rise | scl_fall)) |
	(ext_clk & clock_strobe_bit & tc_strobe);

usc_shift u_shift (
	.aclk      (aclk),
	.aresetn   (aresetn),
	.shift_en  (shift_en),
	.shift_in  (sda_s),
	.load      (wr_data),
	.load_data (wbyte),
	.cnt_inc   (cnt_inc),
	.cnt_load  (wr_stat),
	.cnt_data  (wbyte[3:0]),
	.data      (shift_data_register),
	.cnt       (cnt),
	.wrap      (wrap)
);

////////////////////////////////////////////////////////////////////////////////
// output latch

// open while the clock sits before its sampling edge, always when internal
wire latch_open = ~ext_clk | (scl_s == clock_source_select[0]);

always @(posedge aclk) begin
	if (!aresetn) begin
		out_latch <= 1'b0;
	end else if (latch_open) begin
		out_latch <= shift_data_register[7];
	end
end

////////////////////////////////////////////////////////////////////////////////
// start detector and flags

// start: data falls while clock is high, two-wire mode only
wire start_cond = two_wire & sda_prev & ~sda_s & scl_s & scl_prev;
// with outputs off or three-wire and the strobe bit clear, any edge of an external clock sets it
wire edge_set = ~two_wire & ext_clk & ~clock_strobe_bit &
	(scl_rise | scl_fall);
wire start_set = start_cond | edge_set;

// hardware set wins over a software clear in the same cycle
always @(posedge aclk) begin
	if (!aresetn) begin
		start_flag            <= 1'b0;
		counter_overflow_flag <= 1'b0;
	end else begin
		if (start_set) begin
			start_flag <= 1'b1;
		end else if (wr_stat & wbyte[`USC_STAT_SIF]) begin
			start_flag <= 1'b0;
		end
		if (wrap) begin
			counter_overflow_flag <= 1'b1;
		end else if (wr_stat & wbyte[`USC_STAT_OIF]) begin
			counter_overflow_flag <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// pin drive

reg next_sda_o;
reg next_sda_oe;
reg next_sda_pu;
reg next_scl_o;
reg next_scl_oe;
reg next_scl_pu;
reg next_do_o;
reg next_do_oe;
reg next_do_pu;

wire scl_hold = (two_wire & start_flag) |
	((wire_mode_select == `USC_WM_TWO_HOLD) & counter_overflow_flag);

// wire mode shapes only the drivers, never the inputs
always @* begin
	// plain port behaviour by default
	next_sda_o  = port_sda;
	next_sda_oe = ddr_sda;
	next_sda_pu = ~ddr_sda & port_sda;
	next_scl_o  = port_scl;
	next_scl_oe = clock_pin_direction_bit;
	next_scl_pu = ~clock_pin_direction_bit & port_scl;
	next_do_o   = port_do;
	next_do_oe  = ddr_do;
	next_do_pu  = ~ddr_do & port_do;
	if (three_wire) begin
		next_do_o = out_latch;
	end
	if (two_wire) begin
		// open collector: drive only low, enabled by direction bits
		next_sda_o  = 1'b0;
		next_sda_oe = ddr_sda & (~out_latch | ~port_sda);
		next_sda_pu = 1'b0;
		next_scl_o  = 1'b0;
		next_scl_oe = clock_pin_direction_bit &
			(~port_scl | scl_hold);
		next_scl_pu = 1'b0;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		serial_data_in_pin_o  <= 1'b0;
		serial_data_in_pin_oe <= 1'b0;
		serial_data_in_pullup <= 1'b0;
		serial_clock_pin_o    <= 1'b0;
		serial_clock_pin_oe   <= 1'b0;
		serial_clock_pullup   <= 1'b0;
		data_out_pin_o        <= 1'b0;
		data_out_pin_oe       <= 1'b0;
		data_out_pullup       <= 1'b0;
	end else begin
		serial_data_in_pin_o  <= next_sda_o;
		serial_data_in_pin_oe <= next_sda_oe;
		serial_data_in_pullup <= next_sda_pu;
		serial_clock_pin_o    <= next_scl_o;
		serial_clock_pin_oe   <= next_scl_oe;
		serial_clock_pullup   <= next_scl_pu;
		data_out_pin_o        <= next_do_o;
		data_out_pin_oe       <= next_do_oe;
		data_out_pullup       <= next_do_pu;
	end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt requests, level while flag, enable and global enable hold

always @(posedge aclk) begin
	if (!aresetn) begin
		start_irq    <= 1'b0;
		overflow_irq <= 1'b0;
	end else begin
		start_irq <= start_flag & global_irq_enable &
			serial_unit_control[`USC_CTRL_SIE];
		overflow_irq <= counter_overflow_flag & global_irq_enable &
			serial_unit_control[`USC_CTRL_OIE];
	end
end

endmodule

`default_nettype wire

// >>> tb/tb.sv
// testbench: register sequences against the serial control block
`timescale 1ns/1ps
`default_nettype none
`include "usc_map.vh"

module tb;
	localparam logic [3:0] o_ct = `USC_OFF_CTRL;
	localparam logic [3:0] o_st = `USC_OFF_STAT;
	localparam logic [3:0] o_da = `USC_OFF_DATA;
	localparam logic [3:0] o_po = `USC_OFF_PORT;
	logic        aclk, aresetn, awvalid, wvalid, bready;
	logic        arvalid, rready, gie, tov;
	logic [3:0]  awaddr, araddr, wstrb, strb;
	logic [31:0] wdata;
	logic [7:0]  v;
	int          errors, checked;
	wire         awready, wready, bvalid, arready, rvalid, sirq, oirq;
	wire         sda_i, sda_o, sda_oe, sda_pu, scl_i, scl_o, scl_oe, scl_pu;
	wire         do_o, do_oe, do_pu;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	// pin and request view: do drive, pull-ups, lines pulled low, requests
	wire [7:0]   pins = {do_oe, do_o, sda_pu, scl_pu, sda_oe & ~sda_o,
		scl_oe & ~scl_o, sirq, oirq};

	usc_top usc_top_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .global_irq_enable(gie),
		.timer0_overflow(tov), .serial_data_in_pin_i(sda_i),
		.serial_data_in_pin_o(sda_o), .serial_data_in_pin_oe(sda_oe),
		.serial_data_in_pullup(sda_pu), .serial_clock_pin_i(scl_i),
		.serial_clock_pin_o(scl_o), .serial_clock_pin_oe(scl_oe),
		.serial_clock_pullup(scl_pu), .data_out_pin_o(do_o),
		.data_out_pin_oe(do_oe), .data_out_pullup(do_pu),
		.start_irq(sirq), .overflow_irq(oirq)
	);
	usc_peer usc_peer_inst (
		.scl_oe(scl_oe), .scl_o(scl_o), .sda_oe(sda_oe), .sda_o(sda_o),
		.scl_line(scl_i), .sda_line(sda_i)
	);

	// 25 MHz clock
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		begin
			$display("checks %0d errors %0d", checked, errors);
			if (errors == 0 && checked > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		begin
			checked++;
			if (g !== e) begin
				errors++;
				$display("BAD t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask

	// pin outputs compared mid-cycle once settled, then back to the edge
	task automatic chk_pin(input logic [7:0] m, input logic [7:0] e);
		begin
			@(negedge aclk);
			chk(pins & m, e);
			@(posedge aclk);
		end
	endtask

	task automatic guard(input int n);
		begin
			if (n >= 60) begin
				errors++;
				report_and_stop();
			end
		end
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		int n;
		begin
			n = 0;
			awaddr <= a;
			wdata <= {24'h0, d};
			wstrb <= strb;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			while ((awvalid || wvalid || bvalid !== 1'b1) && n < 60) begin
				@(posedge aclk);
				n++;
				if (awready === 1'b1) awvalid <= 1'b0;
				if (wready === 1'b1) wvalid <= 1'b0;
			end
			chk({6'h0, bresp}, {6'h0, `USC_RESP_OKAY});
			bready <= 1'b0;
			@(posedge aclk);
			guard(n);
		end
	endtask

	// read and compare; status bits 5..4 are outside this block
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		int n;
		begin
			n = 0;
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			while ((arvalid || rvalid !== 1'b1) && n < 60) begin
				@(posedge aclk);
				n++;
				if (arready === 1'b1) arvalid <= 1'b0;
			end
			rready <= 1'b0;
			v = (a == o_st) ? (rdata[7:0] & 8'hcf) : rdata[7:0];
			chk({6'h0, rresp}, {6'h0, `USC_RESP_OKAY});
			@(posedge aclk);
			guard(n);
			chk(v, e);
		end
	endtask

	// main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, gie, tov} = 8'h0;
		{awaddr, araddr, wdata} = 40'h0;
		{errors, checked} = 64'h0;
		strb = 4'hf;
		wstrb = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(o_ct, `USC_CTRL_RST);
		wr(o_ct, 8'hff);
		rc(o_ct, 8'hfc);
		strb = 4'h0;
		wr(o_ct, 8'h44);
		rc(o_ct, 8'hfc);
		strb = 4'hf;
		wr(o_ct, 8'h10);
		wr(o_po, 8'h10);
		wr(o_da, 8'h81);
		chk_pin(8'hc0, 8'hc0);
		wr(o_st, 8'hce);
		wr(o_ct, 8'h12);
		rc(o_da, 8'h03);
		rc(o_st, 8'h0f);
		chk_pin(8'hc0, 8'h80);
		gie <= 1'b1;
		wr(o_ct, 8'h52);
		rc(o_st, 8'h40);
		chk_pin(8'h01, 8'h01);
		gie <= 1'b0;
		repeat (2) @(posedge aclk);
		chk_pin(8'h01, 8'h00);
		gie <= 1'b1;
		wr(o_st, 8'h40);
		rc(o_st, 8'h00);
		wr(o_ct, 8'h04);
		repeat (3) begin
			tov <= 1'b1;
			@(posedge aclk);
			tov <= 1'b0;
			@(posedge aclk);
		end
		rc(o_st, 8'h03);
		// external clock on rising then falling edge, outputs off
		for (int i = 0; i < 2; i++) begin
			wr(o_st, 8'h80);
			wr(o_ct, {4'h0, 1'b1, i[0], 2'h0});
			wr(o_da, 8'h00);
			usc_peer_inst.send(8'ha5, 4);
			repeat (4) @(posedge aclk);
			rc(o_da, 8'h0a);
			rc(o_st, 8'h88);
		end
		wr(o_st, 8'h80);
		wr(o_ct, 8'h0a);
		wr(o_ct, 8'h0b);
		rc(o_po, 8'h14);
		rc(o_st, 8'h01);
		// two-wire: open drain, no pull-ups, start hold
		wr(o_ct, 8'ha0);
		wr(o_po, 8'h66);
		wr(o_da, 8'h00);
		chk_pin(8'h3a, 8'h08);
		wr(o_da, 8'h80);
		usc_peer_inst.start_cond();
		repeat (4) @(posedge aclk);
		chk_pin(8'h0e, 8'h06);
		wr(o_st, 8'h80);
		repeat (3) @(posedge aclk);
		chk_pin(8'h06, 8'h00);
		wr(o_st, 8'h0f);
		wr(o_ct, 8'h32);
		repeat (3) @(posedge aclk);
		chk_pin(8'h04, 8'h04);
		wr(o_st, 8'h40);
		repeat (3) @(posedge aclk);
		chk_pin(8'h04, 8'h00);
		report_and_stop();
	end
endmodule

`default_nettype wire

// >>> tb/usc_peer.sv
// serial peer: an outside master on the clock and data lines
`timescale 1ns/1ps
`default_nettype none

module usc_peer (
	input  wire logic scl_oe,
	input  wire logic scl_o,
	input  wire logic sda_oe,
	input  wire logic sda_o,
	output wire logic scl_line,
	output wire logic sda_line
);
	logic scl_drv; // peer clock level, 1 = released
	logic sda_drv; // peer data level, 1 = released

	// wired lines with pull-ups: any low driver wins
	assign scl_line = scl_drv & (scl_oe ? scl_o : 1'b1);
	assign sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);

	// idle: clock stands low, data released
	initial begin
		scl_drv = 1'b0;
		sda_drv = 1'b1;
	end

	// n bits msb first, data moves mid low phase, 320 ns per bit
	task automatic send(input logic [7:0] b, input int n);
		begin
			#13;
			for (int i = 0; i < n; i++) begin
				#80 sda_drv = b[7-i];
				#80 scl_drv = 1'b1;
				#160 scl_drv = 1'b0;
			end
			#80 sda_drv = 1'b1;
		end
	endtask

	// data falls while the clock is high
	task automatic start_cond();
		begin
			#13 scl_drv = 1'b1;
			#160 sda_drv = 1'b0;
			#160 scl_drv = 1'b0;
			#160 sda_drv = 1'b1;
		end
	endtask
endmodule

`default_nettype wire

// >>> tb/usc_sva.sv
// port checks on the serial control block: register bus and interrupts
`timescale 1ns/1ps
`default_nettype none

module usc_sva (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        global_irq_enable,
	input wire logic        start_irq,
	input wire logic        overflow_irq
);
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// write answer two edges after both halves are taken, then gone
	b_lat_a:
	assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##2 s_axi_bvalid) else $error("bvalid late");
	b_drop_a:
	assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid kept");
	aw_block_a:
	assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	// read answer one edge after the address, narrow data only
	r_lat_a:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("rvalid late");
	r_drop_a:
	assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid kept");
	r_zero_a:
	assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read data set");
	ar_block_a:
	assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	// requests need the global enable
	irq_gate_a:
	assert property (!global_irq_enable |=> !start_irq && !overflow_irq)
		else $error("interrupt without global enable");

	// main scenarios reached
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(overflow_irq));
	cover property ($rose(start_irq));
endmodule

////////////////////////////////////////////////////////////
bind usc_top usc_sva usc_sva_inst (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .global_irq_enable(global_irq_enable),
	.start_irq(start_irq), .overflow_irq(overflow_irq)
);

`default_nettype wire
